// ---- strap_cfg_pkg.sv ----
// Purpose: shared constants and types for the strap configuration loader
// Assumes: one 10 MHz clock, straps stable around reset release
// Notes: pull defaults double as the configuration shown during reset
package strap_cfg_pkg;

  // ****************************************
  // clocking and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned REFCLK_HZ = 25_000_000;
  // half period in clock cycles, floored, never below one
  localparam int unsigned REFCLK_HALF_RAW = CLK_HZ / (2 * REFCLK_HZ);
  localparam int unsigned REFCLK_HALF_CYC =
    (REFCLK_HALF_RAW < 1) ? 1 : REFCLK_HALF_RAW;
  localparam int unsigned EXT_N_A_STRETCH_CYC = 16;

  // ****************************************
  // internal pull levels of the straps
  // ****************************************
  localparam logic PULL_HOST_ROLE = 1'b1;
  localparam logic PULL_ISOLATE = 1'b1;
  localparam logic PULL_SPEED = 1'b1;
  localparam logic PULL_ADDR_LO = 1'b1;
  localparam logic PULL_ADDR_HI = 1'b0;
  localparam logic PULL_MEM_CFG = 1'b0;
  localparam logic PULL_BOOT_SRC = 1'b0;
  localparam logic PULL_DUPLEX = 1'b1;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic ROLE_PHY = 1'b0;
  localparam logic ROLE_MAC = 1'b1;
  localparam logic SPEED_10 = 1'b0;
  localparam logic SPEED_100 = 1'b1;
  localparam logic DUPLEX_HALF = 1'b0;
  localparam logic DUPLEX_FULL = 1'b1;
  localparam logic SRC_HOST = 1'b0;
  localparam logic SRC_FLASH = 1'b1;
  localparam int unsigned MGMT_ADDR_W = 5;
  localparam int unsigned MGMT_ADDR_LSB = 3;

  // raw strap levels
  typedef struct packed {
    logic hostRole;
    logic isolate;
    logic speed;
    logic duplex;
    logic addrLo;
    logic addrHi;
    logic memCfg;
    logic bootSrc;
  } strap_s;

  // decoded configuration
  typedef struct packed {
    logic macMode;
    logic speed100;
    logic isolated;
    logic fullDuplex;
    logic [MGMT_ADDR_W-1:0] mgmtAddr;
    logic sdramFromFlash;
    logic codeFromFlash;
  } cfg_s;

  localparam strap_s STRAP_PULLS = '{
    hostRole: PULL_HOST_ROLE, isolate: PULL_ISOLATE, speed: PULL_SPEED,
    duplex: PULL_DUPLEX, addrLo: PULL_ADDR_LO, addrHi: PULL_ADDR_HI,
    memCfg: PULL_MEM_CFG, bootSrc: PULL_BOOT_SRC};

endpackage : strap_cfg_pkg

// ---- strap_boot_config_reset.sv ----
// Purpose: sample straps at reset release, decode mode and boot plan,
//   drive a stretched PHY reset and the PHY reference clock
// Assumes: straps held stable at the release of arst_n
// Notes: refclk rate is limited by ref_clk; see divider comment
module strap_boot_config_reset
  import strap_cfg_pkg::*;
#(
  parameter int unsigned STRETCH_CYC = EXT_N_A_STRETCH_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // strap pins, levels include the internal pulls
  input wire logic host_role_strap,
  input wire logic isolate_strap,
  input wire logic speedStrap,
  input wire logic mgmt_addr_strap_lo,
  input wire logic mgmt_addr_strap_hi,
  input wire logic memCfgStrap,
  input wire logic boot_src_strap,
  // reference clock pin, shared with the duplex strap
  input wire logic ext_phy_refclk_in,
  output logic ext_phy_refclk_out,
  output logic ext_phy_refclk_oe,
  // external PHY reset
  output logic ext_n_a,
  // decoded configuration and MII drive control
  output cfg_s cfgOut,
  output logic cfgValid,
  output logic miiOutEn,
  output logic rxErOutEn
);

  // ****************************************
  // sizes and the reset image
  // ****************************************
  // a zero stretch still keeps a one-bit counter so the width stays legal
  localparam int unsigned STRETCH_W =
    (STRETCH_CYC < 1) ? 1 : $clog2(STRETCH_CYC + 1);
  localparam int unsigned DIV_W = $clog2(REFCLK_HALF_CYC + 1);
  localparam logic [STRETCH_W-1:0] STRETCH_LOAD = STRETCH_W'(STRETCH_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REFCLK_HALF_CYC - 1);

  // ****************************************
  // phase, configuration and pin registers
  // ****************************************
  typedef enum logic [1:0] {ST_CAPTURE, ST_STRETCH, ST_RUN} phase_e;

  phase_e phase_r;
  phase_e phase_nxt;
  strap_s straps;
  cfg_s cfg_r;
  cfg_s cfg_nxt;
  logic [STRETCH_W-1:0] stretchCnt_r;
  logic [DIV_W-1:0] divCnt_r;
  logic divWrap;
  logic refclk_r;
  logic refclkOe_r;
  logic phyRstN_r;
  logic valid_r;
  logic miiEn_r;
  logic rxErEn_r;

  // ****************************************
  // strap decoding
  // ****************************************
  // the role strap alone picks the MII side
  function automatic logic is_mac(input strap_s s);
    return (s.hostRole == ROLE_MAC);
  endfunction : is_mac

  // address straps sit just above MGMT_ADDR_LSB zero bits
  function automatic logic [MGMT_ADDR_W-1:0] mgmt_addr(input strap_s s);
    logic [MGMT_ADDR_W-1:0] a;
    a = MGMT_ADDR_W'({s.addrHi, s.addrLo});
    a = a << MGMT_ADDR_LSB;
    return a;
  endfunction : mgmt_addr

  // result is {applet from flash, code from flash}; boot flash with a
  // host applet simply takes each strap at its own meaning
  function automatic logic [1:0] boot_plan(input strap_s s);
    logic [1:0] p;
    p = {SRC_HOST, SRC_HOST};
    case ({s.bootSrc, s.memCfg})
      {SRC_HOST, SRC_HOST}: begin
        p = {SRC_HOST, SRC_HOST};
      end
      {SRC_HOST, SRC_FLASH}: begin
        p = {SRC_FLASH, SRC_HOST};
      end
      {SRC_FLASH, SRC_HOST}: begin
        p = {SRC_HOST, SRC_FLASH};
      end
      {SRC_FLASH, SRC_FLASH}: begin
        p = {SRC_FLASH, SRC_FLASH};
      end
      default: begin
        p = {SRC_HOST, SRC_HOST};
      end
    endcase
    return p;
  endfunction : boot_plan

  // pin drive follows the latched mode only, never the reset image
  function automatic logic mac_live(input logic v, input cfg_s c);
    return v && c.macMode;
  endfunction : mac_live

  function automatic logic phy_live(input logic v, input cfg_s c);
    return v && !c.macMode;
  endfunction : phy_live

  // speed, isolate, duplex and address straps only act in PHY mode; MAC mode reports zeros for them
  function automatic cfg_s decode(input strap_s s);
    cfg_s c;
    logic [1:0] plan;
    c = '0;
    plan = boot_plan(s);
    c.macMode = is_mac(s);
    if (!is_mac(s)) begin
      c.speed100 = (s.speed == SPEED_100);
      c.isolated = s.isolate;
      c.fullDuplex = (s.duplex == DUPLEX_FULL);
      c.mgmtAddr = mgmt_addr(s);
    end
    c.sdramFromFlash = (plan[1] == SRC_FLASH);
    c.codeFromFlash = (plan[0] == SRC_FLASH);
    return c;
  endfunction : decode

  // shown while reset is held: the pull levels alone
  localparam cfg_s CFG_PULLS = decode(STRAP_PULLS);

  // ****************************************
  // strap capture
  // ****************************************
  assign straps = '{
    hostRole: host_role_strap,
    isolate: isolate_strap,
    speed: speedStrap,
    duplex: ext_phy_refclk_in,
    addrLo: mgmt_addr_strap_lo,
    addrHi: mgmt_addr_strap_hi,
    memCfg: memCfgStrap,
    bootSrc: boot_src_strap};

  // only the capture edge looks at the pins; firmware may drive LEDs on
  // them afterwards without disturbing the mode
  assign cfg_nxt =
    (phase_r == ST_CAPTURE) ? decode(straps) : cfg_r;

  // ****************************************
  // reset phases
  // ****************************************
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      ST_CAPTURE: begin
        phase_nxt = ST_STRETCH;
      end
      ST_STRETCH: begin
        if (stretchCnt_r == '0) begin
          phase_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        phase_nxt = ST_RUN;
      end
      default: begin
        phase_nxt = ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= ST_CAPTURE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ****************************************
  // latched configuration
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= CFG_PULLS;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // valid rises on the capture edge and holds until the next reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_r <= 1'b0;
    end else if (phase_r == ST_CAPTURE) begin
      valid_r <= 1'b1;
    end
  end

  // ****************************************
  // stretched PHY reset
  // ****************************************
  // the count starts on the edge after capture, so the PHY leaves reset
  // STRETCH_CYC + 2 edges after the release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stretchCnt_r <= STRETCH_LOAD;
    end else if (phase_r == ST_STRETCH && stretchCnt_r != '0) begin
      stretchCnt_r <= stretchCnt_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phyRstN_r <= 1'b0;
    end else begin
      phyRstN_r <= (phase_nxt == ST_RUN);
    end
  end

  // ****************************************
  // reference clock
  // ****************************************
  // a 10 MHz clock cannot reach 25 MHz; the divider floors at one cycle,
  // so a faster ref_clk is needed for the true rate
  assign divWrap = (divCnt_r >= DIV_LAST);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_r <= '0;
    end else if (!mac_live(valid_r, cfg_r) || divWrap) begin
      divCnt_r <= '0;
    end else begin
      divCnt_r <= divCnt_r + 1'b1;
    end
  end

  // the clock parks low outside MAC mode so a later enable starts clean
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      refclk_r <= 1'b0;
    end else if (!mac_live(valid_r, cfg_r)) begin
      refclk_r <= 1'b0;
    end else if (divWrap) begin
      refclk_r <= ~refclk_r;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      refclkOe_r <= 1'b0;
    end else begin
      refclkOe_r <= mac_live(valid_r, cfg_r);
    end
  end

  // ****************************************
  // MII drive
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      miiEn_r <= 1'b0;
    end else begin
      miiEn_r <= phy_live(valid_r, cfg_r) && !cfg_r.isolated;
    end
  end

  // receive error keeps driving even when isolated, so it cannot share
  // a bus with other drivers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxErEn_r <= 1'b0;
    end else begin
      rxErEn_r <= phy_live(valid_r, cfg_r);
    end
  end

  // ****************************************
  // outputs, straight from the registers
  // ****************************************
  assign ext_phy_refclk_out = refclk_r;
  assign ext_phy_refclk_oe = refclkOe_r;
  assign ext_n_a = phyRstN_r;
  assign cfgOut = cfg_r;
  assign cfgValid = valid_r;
  assign miiOutEn = miiEn_r;
  assign rxErOutEn = rxErEn_r;

endmodule : strap_boot_config_reset

// ---- strap_boot_config_reset_chk.sv ----
// Purpose: port checks of the strap loader
// Assumes: one clock, async active-low reset
// Notes: bound to every loader instance
module strap_boot_config_reset_chk
  import strap_cfg_pkg::*;
#(
  parameter int unsigned STRETCH_CYC = EXT_N_A_STRETCH_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // watched outputs
  input wire logic ext_phy_refclk_out,
  input wire logic ext_phy_refclk_oe,
  input wire logic ext_n_a,
  input wire cfg_s cfgOut,
  input wire logic cfgValid,
  input wire logic miiOutEn,
  input wire logic rxErOutEn
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned lowCnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // counts held-low cycles once straps are latched
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) lowCnt_r <= 0;
    else if (cfgValid && !ext_n_a) lowCnt_r <= lowCnt_r + 1;
  end
  AST_STRETCH: assert property (
    $rose(ext_n_a) |-> lowCnt_r == STRETCH_CYC + 1) else $error("stretch");
  AST_RST_LOW: assert property (
    !cfgValid |-> !ext_n_a) else $error("phy reset early");
  AST_HOLD: assert property (
    cfgValid && $past(cfgValid) |-> $stable(cfgOut)) else $error("cfg moved");
  AST_OE_MAC: assert property (
    ext_phy_refclk_oe |-> cfgOut.macMode) else $error("refclk in phy mode");
  AST_OE_ON: assert property (
    $rose(cfgValid) && cfgOut.macMode |=> ext_phy_refclk_oe)
    else $error("refclk not driven");
  AST_TOGGLE: assert property (
    ext_phy_refclk_oe && $past(ext_phy_refclk_oe)
    |-> $changed(ext_phy_refclk_out)) else $error("refclk stuck");
  AST_MII: assert property (
    $past(cfgValid) |-> miiOutEn == (!cfgOut.macMode && !cfgOut.isolated))
    else $error("mii drive");
  AST_RXER: assert property (
    $past(cfgValid) |-> rxErOutEn == !cfgOut.macMode) else $error("rx err");
endmodule : strap_boot_config_reset_chk

bind strap_boot_config_reset strap_boot_config_reset_chk #(
  .STRETCH_CYC(STRETCH_CYC)
) chk (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .ext_phy_refclk_out(ext_phy_refclk_out),
  .ext_phy_refclk_oe(ext_phy_refclk_oe),
  .ext_n_a(ext_n_a),
  .cfgOut(cfgOut),
  .cfgValid(cfgValid),
  .miiOutEn(miiOutEn),
  .rxErOutEn(rxErOutEn)
);

// ---- strap_board.sv ----
// Purpose: board side, strap resistors and the shared refclk pin
// Assumes: wanted levels come from the bench
// Notes: resistor-set levels yield to the loader's drive
module strap_board
  import strap_cfg_pkg::*;
(
  // wanted levels and loader pins
  input wire strap_s want,
  input wire logic refclkOut,
  input wire logic refclkOe,
  output strap_s pins,
  output logic refclkPin
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pins = want;
  assign refclkPin = refclkOe ? refclkOut : want.duplex;
endmodule : strap_board

// ---- strap_boot_config_reset_bench.sv ----
// Purpose: boots the loader under a table of strap settings
// Assumes: stretch shortened to 2 cycles
// Notes: straps flipped after capture must not show
module strap_boot_config_reset_bench
  import strap_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned STR = 2;
  localparam strap_s CASES [7] = '{STRAP_PULLS, 8'h09, 8'h76, 8'h0f,
    8'h00, 8'h78, 8'h83};
  logic refClk = 1'b0;
  logic arstN = 1'b0;
  strap_s want = STRAP_PULLS;
  strap_s pins;
  logic refclkPin, refOut, refOe, phyRstN, cfgValid, miiEn, rxEn;
  cfg_s cfgOut;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  always #50 refClk = ~refClk;
  strap_board board (.want(want), .refclkOut(refOut), .refclkOe(refOe),
    .pins(pins), .refclkPin(refclkPin));
  strap_boot_config_reset #(.STRETCH_CYC(STR)) dut (.ref_clk(refClk),
    .arst_n(arstN), .host_role_strap(pins.hostRole),
    .isolate_strap(pins.isolate), .speedStrap(pins.speed),
    .mgmt_addr_strap_lo(pins.addrLo), .mgmt_addr_strap_hi(pins.addrHi),
    .memCfgStrap(pins.memCfg), .boot_src_strap(pins.bootSrc),
    .ext_phy_refclk_in(refclkPin), .ext_phy_refclk_out(refOut),
    .ext_phy_refclk_oe(refOe), .ext_n_a(phyRstN), .cfgOut(cfgOut),
    .cfgValid(cfgValid), .miiOutEn(miiEn), .rxErOutEn(rxEn));
  task automatic chk(string nm, logic [10:0] e, logic [10:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  function automatic cfg_s expect_cfg(strap_s s);
    cfg_s e;
    e = '0;
    e.macMode = s.hostRole;
    e.sdramFromFlash = s.memCfg;
    e.codeFromFlash = s.bootSrc;
    if (!s.hostRole) begin
      e.speed100 = s.speed;
      e.isolated = s.isolate;
      e.fullDuplex = s.duplex;
      e.mgmtAddr = {s.addrHi, s.addrLo, 3'h0};
    end
    return e;
  endfunction : expect_cfg
  task automatic run(int i);
    cfg_s e;
    logic r;
    e = expect_cfg(CASES[i]);
    arstN = 1'b0;
    want = CASES[i];
    repeat (2) @(posedge refClk);
    #1;
    chk("valid in reset", 11'h0, 11'(cfgValid));
    chk("phy reset in reset", 11'h0, 11'(phyRstN));
    arstN = 1'b1;
    @(posedge refClk);
    #1;
    chk("cfg", e, cfgOut);
    chk("valid", 11'h1, 11'(cfgValid));
    want = ~CASES[i];
    @(posedge refClk);
    #1;
    chk("refclk oe", 11'(e.macMode), 11'(refOe));
    chk("mii", 11'(!e.macMode && !e.isolated), 11'(miiEn));
    chk("rx err", 11'(!e.macMode), 11'(rxEn));
    repeat (STR - 1) @(posedge refClk);
    #1;
    r = refOut;
    chk("phy reset held", 11'h0, 11'(phyRstN));
    @(posedge refClk);
    #1;
    chk("phy reset out", 11'h1, 11'(phyRstN));
    chk("cfg held", e, cfgOut);
    if (e.macMode) chk("refclk", 11'(!r), 11'(refOut));
    $display("test %0d done", i);
  endtask : run
  initial begin
    repeat (5) @(posedge refClk);
    #1;
    for (int i = 0; i < 7; i++) run(i);
    finish_test();
  end
  // cut a hang well past the expected 47 cycles
  always @(posedge refClk) begin
    cyc++;
    if (cyc == 200) begin
      n_mismatch++;
      finish_test();
    end
  end
endmodule : strap_boot_config_reset_bench
